// ==== rtl/sorr_pkg.sv ====
// constants of the sensor output readout register bank
// assumes a classic wishbone slave with 32-bit data, one byte per word
package sorr_pkg;
  localparam int DATA_W   = 32;  // wishbone data width
  localparam int BYTE_W   = 8;   // one register byte
  localparam int WB_ADR_W = 9;   // byte address bits decoded
  localparam int IDX_LSB  = 2;   // word address starts here
  localparam int IDX_W    = 7;   // register index width
  localparam int PRESS_W  = 24;  // pressure result width
  localparam int TEMP_W   = 16;  // temperature result width
  localparam int OFFS_W   = 16;  // calibration offset width
  localparam int FIFO_W   = PRESS_W + TEMP_W;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PRESS_LOW  = 7'h28;
  localparam logic [IDX_W-1:0] IDX_PRESS_MID  = 7'h29;
  localparam logic [IDX_W-1:0] IDX_PRESS_HIGH = 7'h2a;
  localparam logic [IDX_W-1:0] IDX_TEMP_LOW   = 7'h2b;
  localparam logic [IDX_W-1:0] IDX_TEMP_HIGH  = 7'h2c;
  localparam logic [IDX_W-1:0] IDX_FILT_CLR   = 7'h3c;
  localparam logic [IDX_W-1:0] IDX_Q_PRESS_L  = 7'h78;
  localparam logic [IDX_W-1:0] IDX_Q_PRESS_M  = 7'h79;
  localparam logic [IDX_W-1:0] IDX_Q_PRESS_H  = 7'h7a;
  localparam logic [IDX_W-1:0] IDX_Q_TEMP_L   = 7'h7b;
  localparam logic [IDX_W-1:0] IDX_Q_TEMP_H   = 7'h7c;

  // byte lane numbers inside a multi-byte result
  localparam int LANE_LOW  = 0;
  localparam int LANE_MID  = 1;
  localparam int LANE_HIGH = 2;

  // reset values
  localparam logic [PRESS_W-1:0] PRESS_RST = 24'h000000;
  localparam logic [TEMP_W-1:0]  TEMP_RST  = 16'h0000;
  localparam logic [BYTE_W-1:0]  BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0]  DATA_RST  = 32'h00000000;

  // byte n of a result word, counted from the least significant
  function automatic logic [BYTE_W-1:0] byte_of(
    input logic [PRESS_W-1:0] v,
    input int                 n
  );
    byte_of = v[n*BYTE_W +: BYTE_W];
  endfunction
endpackage

// ==== rtl/sorr_regs.sv ====
// read-only output register bank with classic wishbone slave
// assumes measurement, fifo and filter signals come from logic on mclk
// and the fifo shows its oldest entry on fifo_head while not empty

// Contract
// RULE_01 - Pressure bits 23 to 16 are read at offset 0x2A.
// RULE_02 - Temperature low byte reads at 0x2B and high byte at 0x2C.
// RULE_03 - Temperature is two's complement, sign in the high byte msb.
// RULE_04 - Reading 0x3C resets the active pressure filter; host does it first.
// RULE_05 - Queued pressure reads low, mid, high at 0x78, 0x79, 0x7A.
// RULE_06 - Queued temperature reads low at 0x7B and high at 0x7C.
// RULE_07 - Pressure is 24-bit two's complement over 0x28, 0x29, 0x2A.
// RULE_08 - With reference modes off, pressure is raw minus signed offset.
// RULE_09 - The host may read fifo bytes singly or as consecutive bursts.
// RULE_10 - Writes to any register are ignored and leave results intact.
module sorr_regs (
  input  wire logic                          mclk,        // clock, 25 MHz
  input  wire logic                          srst,        // sync reset
  input  wire logic                          wb_cyc_i,    // bus cycle
  input  wire logic                          wb_stb_i,    // strobe
  input  wire logic                          wb_we_i,     // write enable
  input  wire logic [sorr_pkg::WB_ADR_W-1:0] wb_adr_i,    // byte address
  input  wire logic [3:0]                    wb_sel_i,    // byte lanes
  input  wire logic [sorr_pkg::DATA_W-1:0]   wb_dat_i,    // write data
  output logic      [sorr_pkg::DATA_W-1:0]   wb_dat_o,    // read data
  output logic                               wb_ack_o,    // acknowledge
  input  wire logic [sorr_pkg::PRESS_W-1:0]  meas_press,  // raw pressure
  input  wire logic [sorr_pkg::TEMP_W-1:0]   meas_temp,   // raw temperature
  input  wire logic                          meas_valid,  // sample strobe
  input  wire logic [sorr_pkg::OFFS_W-1:0]   calibration_offset, // signed
  input  wire logic                          differential_enable, // mode
  input  wire logic                          self_zeroing,   // mode
  input  wire logic                          self_reference, // mode
  input  wire logic                          pressure_smoothing_filter, // on
  output logic                               filter_clear,   // clear pulse
  input  wire logic [sorr_pkg::FIFO_W-1:0]   fifo_head,   // {temp, press}
  input  wire logic                          fifo_empty,  // no entry
  output logic                               fifo_pop     // pop pulse
);
  sorr_result_if res_if ();

  sorr_result_calc u_calc (
    .mclk                (mclk),
    .srst                (srst),
    .meas_press          (meas_press),
    .meas_temp           (meas_temp),
    .meas_valid          (meas_valid),
    .calibration_offset  (calibration_offset),
    .differential_enable (differential_enable),
    .self_zeroing        (self_zeroing),
    .self_reference      (self_reference),
    .res                 (res_if.calc)
  );

  // request decode
  logic                           req_take;
  logic                           rd_take;
  logic [sorr_pkg::IDX_W-1:0]     idx;
  logic [sorr_pkg::PRESS_W-1:0]   q_press;
  logic [sorr_pkg::PRESS_W-1:0]   cur_temp_w;
  logic [sorr_pkg::PRESS_W-1:0]   q_temp_w;
  logic [sorr_pkg::BYTE_W-1:0]    rd_byte;
  logic                           hit_filt;
  logic                           hit_pop;
  logic                           ack_r;
  logic                           ack_nxt;
  logic [sorr_pkg::DATA_W-1:0]    dat_r;
  logic [sorr_pkg::DATA_W-1:0]    dat_nxt;
  logic                           clr_r;
  logic                           clr_nxt;
  logic                           pop_r;
  logic                           pop_nxt;

  // one answer per request; ack drops the cycle after it is given
  assign req_take = wb_cyc_i & wb_stb_i & !ack_r;
  // writes are answered but never reach any storage
  assign rd_take  = req_take & !wb_we_i;  // RULE_10
  assign idx      = wb_adr_i[sorr_pkg::WB_ADR_W-1:sorr_pkg::IDX_LSB];

  assign q_press    = fifo_head[sorr_pkg::PRESS_W-1:0];
  assign cur_temp_w = {{(sorr_pkg::PRESS_W-sorr_pkg::TEMP_W){1'b0}},
                       res_if.temp};
  assign q_temp_w   = {{(sorr_pkg::PRESS_W-sorr_pkg::TEMP_W){1'b0}},
                       fifo_head[sorr_pkg::FIFO_W-1:sorr_pkg::PRESS_W]};

  // read selection; filter clear and unmapped offsets read as zero
  assign rd_byte =
    (idx == sorr_pkg::IDX_PRESS_LOW)  ?
      sorr_pkg::byte_of(res_if.press, sorr_pkg::LANE_LOW)  :  // RULE_07
    (idx == sorr_pkg::IDX_PRESS_MID)  ?
      sorr_pkg::byte_of(res_if.press, sorr_pkg::LANE_MID)  :  // RULE_07
    (idx == sorr_pkg::IDX_PRESS_HIGH) ?
      sorr_pkg::byte_of(res_if.press, sorr_pkg::LANE_HIGH) :  // RULE_01
    (idx == sorr_pkg::IDX_TEMP_LOW)   ?
      sorr_pkg::byte_of(cur_temp_w, sorr_pkg::LANE_LOW)    :  // RULE_02
    (idx == sorr_pkg::IDX_TEMP_HIGH)  ?
      sorr_pkg::byte_of(cur_temp_w, sorr_pkg::LANE_MID)    :  // RULE_03
    (idx == sorr_pkg::IDX_Q_PRESS_L)  ?
      sorr_pkg::byte_of(q_press, sorr_pkg::LANE_LOW)       :  // RULE_05
    (idx == sorr_pkg::IDX_Q_PRESS_M)  ?
      sorr_pkg::byte_of(q_press, sorr_pkg::LANE_MID)       :  // RULE_05
    (idx == sorr_pkg::IDX_Q_PRESS_H)  ?
      sorr_pkg::byte_of(q_press, sorr_pkg::LANE_HIGH)      :  // RULE_05
    (idx == sorr_pkg::IDX_Q_TEMP_L)   ?
      sorr_pkg::byte_of(q_temp_w, sorr_pkg::LANE_LOW)      :  // RULE_06
    (idx == sorr_pkg::IDX_Q_TEMP_H)   ?
      sorr_pkg::byte_of(q_temp_w, sorr_pkg::LANE_MID)      :  // RULE_06
      sorr_pkg::BYTE_ZERO;

  // side effects of reads
  assign hit_filt = rd_take & (idx == sorr_pkg::IDX_FILT_CLR);
  // last byte of an entry retires it, so bursts 0x78..0x7c pop once
  assign hit_pop  = rd_take & (idx == sorr_pkg::IDX_Q_TEMP_H) & !fifo_empty;

  assign ack_nxt = req_take;
  assign dat_nxt = rd_take ?
                   {{(sorr_pkg::DATA_W-sorr_pkg::BYTE_W){1'b0}}, rd_byte} :
                   sorr_pkg::DATA_RST;
  assign clr_nxt = hit_filt & pressure_smoothing_filter;  // RULE_04
  assign pop_nxt = hit_pop;                               // RULE_09

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_r <= 1'b0;
      dat_r <= sorr_pkg::DATA_RST;
      clr_r <= 1'b0;
      pop_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      clr_r <= clr_nxt;
      pop_r <= pop_nxt;
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;
  assign filter_clear = clr_r;
  assign fifo_pop     = pop_r;
endmodule // sorr_regs

// ==== rtl/sorr_result_calc.sv ====
// result holder: pressure, offset-corrected only with all reference modes off, and temperature
// assumes measurement strobe and data come from logic on mclk
module sorr_result_calc (
  input  wire logic                         mclk,        // clock
  input  wire logic                         srst,        // sync reset
  input  wire logic [sorr_pkg::PRESS_W-1:0] meas_press,  // raw pressure
  input  wire logic [sorr_pkg::TEMP_W-1:0]  meas_temp,   // raw temperature
  input  wire logic                         meas_valid,  // new sample
  input  wire logic [sorr_pkg::OFFS_W-1:0]  calibration_offset, // signed
  input  wire logic                         differential_enable, // mode
  input  wire logic                         self_zeroing,   // mode
  input  wire logic                         self_reference, // mode
  sorr_result_if.calc                       res          // to the bank
);
  logic [sorr_pkg::PRESS_W-1:0] press_r;
  logic [sorr_pkg::PRESS_W-1:0] press_nxt;
  logic [sorr_pkg::TEMP_W-1:0]  temp_r;
  logic [sorr_pkg::TEMP_W-1:0]  temp_nxt;
  logic [sorr_pkg::PRESS_W-1:0] offs_ext;
  logic                         plain_mode;

  // sign-extend the 16-bit offset to the pressure width
  assign offs_ext = {{(sorr_pkg::PRESS_W-sorr_pkg::OFFS_W)
                      {calibration_offset[sorr_pkg::OFFS_W-1]}},
                     calibration_offset};
  assign plain_mode = !(differential_enable | self_zeroing | self_reference);
  // reference modes are handled upstream; raw value passes through then
  assign press_nxt = !meas_valid ? press_r :
                     plain_mode  ? meas_press - offs_ext :  // RULE_08
                                   meas_press;              // RULE_07
  assign temp_nxt  = meas_valid ? meas_temp : temp_r;       // RULE_03

  always_ff @(posedge mclk) begin
    if (srst) begin
      press_r <= sorr_pkg::PRESS_RST;
      temp_r  <= sorr_pkg::TEMP_RST;
    end else begin
      press_r <= press_nxt;
      temp_r  <= temp_nxt;
    end
  end

  assign res.press = press_r;
  assign res.temp  = temp_r;
endmodule // sorr_result_calc

// ==== rtl/sorr_result_if.sv ====
// carrier of the current measurement result between calc and bank
// assumes both ends share mclk
interface sorr_result_if;
  logic [sorr_pkg::PRESS_W-1:0] press;  // signed pressure result
  logic [sorr_pkg::TEMP_W-1:0]  temp;   // signed temperature result

  modport calc (output press, output temp);
  modport bank (input press, input temp);
endinterface

// ==== tb/sorr_host_model.sv ====
// host model: classic wishbone master doing single cycles
// assumes the slave acks some cycles after the request
module sorr_host_model (
  input  wire logic        mclk,     // clock
  input  wire logic        ack,      // slave ack
  input  wire logic [31:0] rdat,     // slave read data
  output logic             cyc,      // cycle
  output logic             stb,      // strobe
  output logic             we,       // write
  output logic [8:0]       adr,      // byte address
  output logic [31:0]      wdat      // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cyc, stb, we, adr, wdat} = '0;
  // single or back-to-back reads are both legal
  task automatic xfer(input logic w, input logic [8:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, wd};
    do @(posedge mclk); while (ack !== 1'b1);
    d = rdat;
    {cyc, stb} <= 2'b00;
  endtask
endmodule // sorr_host_model

// ==== tb/sorr_regs_checker.sv ====
// bus and pulse checks for the readout register bank
// assumes binding to sorr_regs, single mclk domain
module sorr_regs_checker (
  input wire logic        mclk,                      // clock
  input wire logic        srst,                      // sync reset
  input wire logic        wb_cyc_i,                  // cycle
  input wire logic        wb_stb_i,                  // strobe
  input wire logic        wb_we_i,                   // write
  input wire logic [8:0]  wb_adr_i,                  // byte address
  input wire logic [31:0] wb_dat_o,                  // read data
  input wire logic        wb_ack_o,                  // acknowledge
  input wire logic        pressure_smoothing_filter, // filter on
  input wire logic        filter_clear,              // clear pulse
  input wire logic [39:0] fifo_head,                 // oldest entry
  input wire logic        fifo_empty,                // no entry
  input wire logic        fifo_pop                   // pop pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire [6:0] idx  = wb_adr_i[8:2];
  wire       take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       rd   = take & ~wb_we_i;
  a_ack_answers: assert property (take |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_clear_made: assert property (rd && idx == 7'h3c &&
    pressure_smoothing_filter |=> filter_clear) else $error("no clear");
  a_clear_cause: assert property (filter_clear |-> wb_ack_o &&
    $past(rd && idx == 7'h3c && pressure_smoothing_filter))
    else $error("stray filter clear");
  a_pop_made: assert property (rd && idx == 7'h7c && !fifo_empty
    |=> fifo_pop) else $error("no pop after last queued byte");
  a_pop_cause: assert property (fifo_pop |-> wb_ack_o &&
    $past(rd && idx == 7'h7c && !fifo_empty)) else $error("stray pop");
  a_qtemp_high: assert property (rd && idx == 7'h7c |=>
    wb_dat_o == {24'h000000, $past(fifo_head[39:32])})
    else $error("queued temperature high byte wrong");
  a_write_quiet: assert property (wb_ack_o && $past(wb_we_i) |->
    wb_dat_o == 32'h0 && !fifo_pop && !filter_clear)
    else $error("write had an effect");
  c_clear: cover property (filter_clear);
  c_pop: cover property (fifo_pop);
  c_write: cover property (wb_ack_o && $past(wb_we_i));
endmodule // sorr_regs_checker

bind sorr_regs sorr_regs_checker u_chk (.mclk(mclk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pressure_smoothing_filter(pressure_smoothing_filter),
  .filter_clear(filter_clear), .fifo_head(fifo_head),
  .fifo_empty(fifo_empty), .fifo_pop(fifo_pop));

// ==== tb/test_sorr_regs.sv ====
// self-checking bench for the readout register bank
// assumes 25 MHz mclk and the host model as bus master
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module test_sorr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, cyc, stb, we, ack, mv, de, filt, clr, emp, pop, sz, sr;
  logic [8:0] adr;
  logic [31:0] wd, rdat, d;
  logic [23:0] mp;
  logic [15:0] mt, offs;
  logic [39:0] head;
  int errors, n_compared, cyc_n, pops, clears;
  sorr_host_model host (.mclk(mclk), .ack(ack), .rdat(rdat), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .wdat(wd));
  sorr_regs u_sorr_regs (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_press(mp),
    .meas_temp(mt), .meas_valid(mv), .calibration_offset(offs),
    .differential_enable(de), .self_zeroing(sz), .self_reference(sr),
    .pressure_smoothing_filter(filt), .filter_clear(clr),
    .fifo_head(head), .fifo_empty(emp), .fifo_pop(pop));
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    // pulses are unknown until the first reset edge
    if (!srst) begin
      pops <= pops + pop;
      clears <= clears + clr;
    end
    cyc_n++;
    if (cyc_n == 3000) begin
      errors++;
      results();
    end
  end
  task automatic rd(input logic [6:0] i);
    host.xfer(1'b0, {i, 2'b00}, 32'h0, d);
    repeat (2) @(posedge mclk);
  endtask
  task automatic chk5(input logic [6:0] b, input logic [39:0] e);
    for (int k = 0; k < 5; k++) begin
      rd(b + 7'(k));
      `CHK(d, {24'h0, e[8*k +: 8]})
    end
  endtask
  task automatic meas(input logic [23:0] p, input logic [15:0] t);
    @(posedge mclk);
    {mp, mt, mv} <= {p, t, 1'b1};
    @(posedge mclk);
    mv <= 1'b0;
  endtask
  task automatic t_filter();
    filt <= 1'b1;
    rd(7'h3c);
    `CHK(d, 32'h0)
    `CHK(clears, 1)
    filt <= 1'b0;
    rd(7'h3c);
    `CHK(clears, 1)
    $display("t_filter done");
  endtask
  task automatic t_meas();
    offs <= 16'hff00;
    meas(24'h123456, 16'hf9c4);
    chk5(7'h28, {16'hf9c4, 24'h123556});
    de <= 1'b1;
    meas(24'h800010, 16'h0123);
    chk5(7'h28, {16'h0123, 24'h800010});
    de <= 1'b0;
    sz <= 1'b1;
    meas(24'h400020, 16'h0045);
    chk5(7'h28, {16'h0045, 24'h400020});
    sz <= 1'b0;
    sr <= 1'b1;
    meas(24'h800010, 16'h0123);
    chk5(7'h28, {16'h0123, 24'h800010});
    sr <= 1'b0;
    $display("t_meas done");
  endtask
  task automatic t_fifo();
    head <= 40'h8a7bc1d2e3;
    emp <= 1'b0;
    chk5(7'h78, 40'h8a7bc1d2e3);
    `CHK(pops, 1)
    emp <= 1'b1;
    rd(7'h7c);
    `CHK(pops, 1)
    $display("t_fifo done");
  endtask
  task automatic t_write();
    host.xfer(1'b1, {7'h2a, 2'b00}, 32'hffffffff, d);
    `CHK(d, 32'h0)
    rd(7'h2a);
    `CHK(d, 32'h80)
    rd(7'h10);
    `CHK(d, 32'h0)
    $display("t_write done");
  endtask
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {srst, mv, de, sz, sr, filt, emp, mp, mt, offs, head} = '0;
    srst = 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_filter();
    t_meas();
    t_fifo();
    t_write();
    results();
  end
endmodule // test_sorr_regs
